// [design/sacl_pkg.sv]
// Shared constants for the successive-approximation converter control block
package sacl_pkg;
   // Register address and reset value of the mode register
   localparam logic [15:0] MODE_ADDR     = 16'hFF80;
   localparam logic [7:0]  MODE_RESET    = 8'h01;
   // Field positions inside the mode register
   localparam int          RUN_BIT       = 7;
   localparam int          TRIG_BIT      = 6;
   localparam int          TIME_HI_BIT   = 5;
   localparam int          TIME_LO_BIT   = 4;
   localparam int          CHAN_MSB      = 3;
   localparam int          CHAN_LSB      = 1;
   localparam int          SPEED_BIT     = 0;
   // Conversion lengths in main-oscillator cycles, short and long variants
   localparam logic [7:0]  LEN_001_SHORT = 8'h50;
   localparam logic [7:0]  LEN_001_LONG  = 8'hA0;
   localparam logic [7:0]  LEN_011_SHORT = 8'h28;
   localparam logic [7:0]  LEN_011_LONG  = 8'h50;
   localparam logic [7:0]  LEN_100_SHORT = 8'h32;
   localparam logic [7:0]  LEN_100_LONG  = 8'h64;
   localparam logic [7:0]  LEN_101_SHORT = 8'h64;
   localparam logic [7:0]  LEN_101_LONG  = 8'hC8;
   // Number of result bits resolved per conversion
   localparam int          RES_BITS      = 8;
   // Edge codes for the external trigger
   localparam logic [1:0]  EDGE_FALL     = 2'h0;
   localparam logic [1:0]  EDGE_RISE     = 2'h1;
   localparam logic [1:0]  EDGE_BOTH     = 2'h3;
endpackage

// [design/sacl_trig_edge.sv]
// Edge detector for the external conversion trigger pin
`timescale 1ns/1ps
`default_nettype none
module sacl_trig_edge (
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   input  wire logic       ce_i,
   input  wire logic       pin_i,
   input  wire logic [1:0] edge_sel_i,
   output var  logic       hit_o
);
   typedef struct packed {
      logic live;
      logic prev;
      logic hit;
   } sacl_edge_state_t;

   sacl_edge_state_t st;
   sacl_edge_state_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // Pick the active edge from the two edge bits
   always_comb begin
      next_st      = st;
      next_st.live = 1'b1;
      next_st.prev = pin_i;
      case (edge_sel_i)
         sacl_pkg::EDGE_FALL: next_st.hit = st.prev & ~pin_i;
         sacl_pkg::EDGE_RISE: next_st.hit = ~st.prev & pin_i;
         sacl_pkg::EDGE_BOTH: next_st.hit = st.prev ^ pin_i;
         default:             next_st.hit = 1'b0; // Code 2 treated as no edge
      endcase
      // First sample after reset only primes the history, so a pin idling high
      // is not mistaken for a rising edge
      if (!st.live) begin
         next_st.hit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign hit_o = st.hit;
endmodule
`default_nettype wire

// [design/sacl_top.sv]
// Control logic of an 8-channel, 8-bit successive-approximation converter
// Notes on behaviour
// - Resolve bits from MSB down, keeping each compare decision.
// - After LSB resolves, copy approximation register into result register.
// - Result register is 8-bit, read-only, reloaded every conversion end.
// - Result register has no defined reset value.
// - Mode register takes single-bit writes and whole-byte writes.
// - Mode register resets to 01H and sits at FF80H.
// - Mode fields: run b7, trigger b6, time b5:4, channel b3:1, speed b0.
// - Channel field value n selects analog input n.
// - Conversion length from time and speed bits; long when divide select 0.
// - Trigger bit 0 means software start, 1 means external trigger start.
// - Run bit 1 starts operation, 0 stops it.
// - Pins not used as analog inputs stay digital port pins.
// - Two edge bits select the external trigger's active edge.
// - Hardware start converts once; software start repeats; flag each end.
// - Hardware trigger comes from third external interrupt pin.
// - Keep bit set when input at or above tap, else clear.
`timescale 1ns/1ps
`default_nettype none
module sacl_top (
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   input  wire logic       ce_i,
   input  wire logic [15:0] addr_i,
   input  wire logic       wr_byte_i,
   input  wire logic       wr_bit_i,
   input  wire logic [2:0] bit_pos_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       osc_divide_select_i,
   input  wire logic [1:0] ext_irq_edge_config_i,
   input  wire logic       ext_trigger_pin_i,
   input  wire logic       cmp_ge_i,
   input  wire logic       flag_clear_i,
   input  wire logic [7:0] analog_pin_count_select_i,
   output var  logic [7:0] adc_mode_control_o,
   output var  logic [7:0] adc_conversion_result_o,
   output var  logic [7:0] approx_tap_o,
   output var  logic [2:0] channel_o,
   output var  logic       converting_o,
   output var  logic       conv_end_irq_flag_o,
   output var  logic       conv_end_irq_o,
   output var  logic [7:0] analog_pin_enable_o
);
   // Gray-coded sequence: idle, waiting for step slot, comparing
   typedef enum logic [1:0] {
      SACL_IDLE = 2'h0,
      SACL_WAIT = 2'h1,
      SACL_CMP  = 2'h3
   } sacl_state_t;

   typedef struct packed {
      sacl_state_t fsm;
      logic [7:0]  mode;
      logic [7:0]  approximation_shift_reg;
      logic [7:0]  trial;
      logic [7:0]  result;
      logic [7:0]  slot_cnt;
      logic        flag;
      logic        irq;
      logic        hw_armed;
      logic [7:0]  pin_en;
      logic        busy;
   } sacl_regs_t;

   sacl_regs_t r;
   sacl_regs_t next_r;
   logic       trig_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion length lookup, used for step pacing
   function automatic logic [7:0] sacl_conv_len(input logic [2:0] code, input logic div_sel);
      logic [7:0] len;
      len = 8'h00;
      case (code)
         3'h1:    len = div_sel ? sacl_pkg::LEN_001_SHORT : sacl_pkg::LEN_001_LONG;
         3'h3:    len = div_sel ? sacl_pkg::LEN_011_SHORT : sacl_pkg::LEN_011_LONG;
         3'h4:    len = div_sel ? sacl_pkg::LEN_100_SHORT : sacl_pkg::LEN_100_LONG;
         3'h5:    len = div_sel ? sacl_pkg::LEN_101_SHORT : sacl_pkg::LEN_101_LONG;
         default: len = sacl_pkg::LEN_001_LONG; // Prohibited codes run the slow path
      endcase
      return len;
   endfunction

   // Wait count per bit step; the remainder of an uneven length goes to the first
   // bit, so every conversion lasts exactly its table length
   function automatic logic [7:0] sacl_step_len(input logic [7:0] mode, input logic div_sel,
                                                input logic first);
      logic [7:0] len;
      logic [7:0] extra;
      len   = sacl_conv_len({mode[sacl_pkg::TIME_HI_BIT], mode[sacl_pkg::TIME_LO_BIT],
                             mode[sacl_pkg::SPEED_BIT]}, div_sel);
      extra = first ? {5'h00, len[2:0]} : 8'h00;
      // The zero count and the compare cycle each take one cycle of the step
      return (len >> 3) + extra - 8'h02;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // External trigger edge detection on the third external interrupt pin
   sacl_trig_edge u_trig (
      .clk_sys_i  (clk_sys_i),
      .resetn_i   (resetn_i),
      .ce_i       (ce_i),
      .pin_i      (ext_trigger_pin_i),
      .edge_sel_i (ext_irq_edge_config_i),
      .hit_o      (trig_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for registers and the step sequencer
   always_comb begin
      logic run;
      logic hw;
      run        = r.mode[sacl_pkg::RUN_BIT];
      hw         = r.mode[sacl_pkg::TRIG_BIT];
      next_r     = r;
      next_r.irq = 1'b0;
      // Pins at or above the selected count remain digital ports
      for (int i = 0; i < 8; i++) begin
         next_r.pin_en[i] = (analog_pin_count_select_i > 8'(i));
      end
      if (flag_clear_i) begin
         next_r.flag = 1'b0;
      end
      if (trig_hit && hw && run) begin
         next_r.hw_armed = 1'b1;
      end
      case (r.fsm)
         SACL_IDLE: begin
            if (run && (!hw || r.hw_armed || (trig_hit && hw))) begin
               next_r.hw_armed = 1'b0;
               next_r.trial    = 8'h80;
               next_r.approximation_shift_reg      = 8'h80;
               next_r.slot_cnt = sacl_step_len(r.mode, osc_divide_select_i, 1'b1);
               next_r.fsm      = SACL_WAIT;
            end
         end
         SACL_WAIT: begin
            if (r.slot_cnt == 8'h00) begin
               next_r.fsm = SACL_CMP;
            end else begin
               next_r.slot_cnt = r.slot_cnt - 8'h01;
            end
         end
         SACL_CMP: begin
            // Keep the trial bit only when input is at or above the tap
            next_r.approximation_shift_reg = cmp_ge_i ? r.approximation_shift_reg : (r.approximation_shift_reg & ~r.trial);
            if (r.trial[0]) begin
               next_r.result = next_r.approximation_shift_reg;
               next_r.flag   = 1'b1;       // Set beats a same-cycle clear
               next_r.irq    = 1'b1;
               // Hardware start converts once; software start loops
               next_r.fsm    = SACL_IDLE;
            end else begin
               next_r.trial    = r.trial >> 1;
               next_r.approximation_shift_reg      = next_r.approximation_shift_reg | (r.trial >> 1);
               next_r.slot_cnt = sacl_step_len(r.mode, osc_divide_select_i, 1'b0);
               next_r.fsm      = SACL_WAIT;
            end
         end
         default: next_r.fsm = SACL_IDLE;
      endcase
      // Stopping aborts any conversion in flight; no result is stored unless the LSB compare falls in the same cycle
      if (!run) begin
         next_r.fsm      = SACL_IDLE;
         next_r.hw_armed = 1'b0;
      end
      // Software writes to the mode register, bit or byte wide
      if (addr_i == sacl_pkg::MODE_ADDR) begin
         if (wr_byte_i) begin
            next_r.mode = wdata_i;
         end else if (wr_bit_i) begin
            next_r.mode[bit_pos_i] = wdata_i[0];
         end
      end
      // Busy is registered so the status pin comes straight from a flop
      next_r.busy = (next_r.fsm != SACL_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; the result is cleared only so one process owns all state,
   // software must still treat it as undefined until a conversion ends
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r.fsm      <= SACL_IDLE;
         r.mode     <= sacl_pkg::MODE_RESET;
         r.approximation_shift_reg      <= 8'h00;
         r.trial    <= 8'h00;
         r.result   <= 8'h00;
         r.slot_cnt <= 8'h00;
         r.flag     <= 1'b0;
         r.irq      <= 1'b0;
         r.hw_armed <= 1'b0;
         r.pin_en   <= 8'h00;
         r.busy     <= 1'b0;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flop
   assign adc_mode_control_o      = r.mode;
   assign adc_conversion_result_o = r.result;
   assign approx_tap_o            = r.approximation_shift_reg;
   assign channel_o               = r.mode[sacl_pkg::CHAN_MSB:sacl_pkg::CHAN_LSB];
   assign converting_o            = r.busy;
   assign conv_end_irq_flag_o     = r.flag;
   assign conv_end_irq_o          = r.irq;
   assign analog_pin_enable_o     = r.pin_en;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_mode_reset_val: assert property (@(posedge clk_sys_i)
      $rose(resetn_i) |-> r.mode == 8'h01) else $error("mode reset value wrong");
   a_result_on_end: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (ce_i && r.fsm == SACL_CMP && r.trial[0] && r.mode[7])
      |=> (r.result == r.approximation_shift_reg && r.irq)) else $error("result not loaded at end");
   a_flag_with_load: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      $changed(r.irq) && r.irq |-> r.flag) else $error("flag not set with result");
   a_msb_first: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (ce_i && r.fsm == SACL_IDLE && next_r.fsm == SACL_WAIT)
      |=> r.trial == 8'h80) else $error("conversion did not start at msb");
   a_cmp_keep_bit: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (ce_i && r.mode[7] && r.fsm == SACL_CMP && !cmp_ge_i)
      |=> (r.approximation_shift_reg & $past(r.trial)) == 8'h00) else $error("bit kept below tap");
   a_stop_idles: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (ce_i && !r.mode[7] && !(wr_byte_i || wr_bit_i)) |=> r.fsm == SACL_IDLE)
      else $error("converter ran while stopped");
   a_byte_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (ce_i && wr_byte_i && addr_i == 16'hFF80) |=> r.mode == $past(wdata_i))
      else $error("byte write lost");
   a_chan_field: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (ce_i && wr_byte_i && addr_i == 16'hFF80) |=> channel_o == $past(wdata_i[3:1]))
      else $error("channel field misplaced");
   c_sw_conv: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
      r.irq && !r.mode[6]);
   c_hw_conv: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
      r.irq && r.mode[6]);
   c_stop_mid: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
      r.fsm == SACL_WAIT ##1 r.fsm == SACL_IDLE && !r.irq);
endmodule
`default_nettype wire

// [tb/sacl_analog_src.sv]
// Behavioural analog source and comparator facing the converter control block
`timescale 1ns/1ps
`default_nettype none
module sacl_analog_src (
   input  wire logic [7:0]  approx_tap_i,
   input  wire logic [2:0]  channel_i,
   input  wire logic [63:0] levels_i,
   output var  logic        cmp_ge_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // One 8-bit level per channel; no noise, so a slip in bit order shows at once
   always_comb begin
      cmp_ge_o = (levels_i[channel_i*8 +: 8] >= approx_tap_i);
   end
endmodule
`default_nettype wire

// [tb/sacl_top_tb_top.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sacl_top_tb_top;
   logic        clk_sys_i = 1'b0;
   logic        resetn_i  = 1'b0;
   logic [15:0] addr_i    = 16'hFF80;
   logic        wr_byte_i = 1'b0;
   logic        wr_bit_i  = 1'b0;
   logic [2:0]  bit_pos_i = 3'h0;
   logic [7:0]  wdata_i   = 8'h00;
   logic        div_sel   = 1'b1;
   logic [1:0]  edge_cfg  = 2'h1;
   logic        trig      = 1'b0;
   logic        flag_clr  = 1'b0;
   logic [7:0]  pin_cnt   = 8'h00;
   logic [63:0] levels    = 64'hFF00_C35A_8001_7F42;
   logic [7:0]  mode, result, tap, pin_en;
   logic [2:0]  chan;
   logic        cmp_ge, busy, flag, irq;
   int          fails     = 0;
   int          n_tests   = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and the block under test with its analog partner
   always #2.5 clk_sys_i = ~clk_sys_i;
   sacl_top u_sacl_top (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1), .addr_i(addr_i),
      .wr_byte_i(wr_byte_i), .wr_bit_i(wr_bit_i), .bit_pos_i(bit_pos_i), .wdata_i(wdata_i),
      .osc_divide_select_i(div_sel), .ext_irq_edge_config_i(edge_cfg), .ext_trigger_pin_i(trig),
      .cmp_ge_i(cmp_ge), .flag_clear_i(flag_clr), .analog_pin_count_select_i(pin_cnt),
      .adc_mode_control_o(mode), .adc_conversion_result_o(result), .approx_tap_o(tap),
      .channel_o(chan), .converting_o(busy), .conv_end_irq_flag_o(flag),
      .conv_end_irq_o(irq), .analog_pin_enable_o(pin_en));
   sacl_analog_src u_sacl_analog_src (
      .approx_tap_i(tap), .channel_i(chan), .levels_i(levels), .cmp_ge_o(cmp_ge));

   ////////////////////////////////////////////////////////////////////////////////
   // Shared compare, verdict, register write and wait helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("Compares %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Strobe held one full cycle, launched and dropped on falling edges
   task automatic wr(input logic [15:0] a, input logic bw, input logic [2:0] p, input logic [7:0] d);
      @(negedge clk_sys_i);
      addr_i = a;
      wr_byte_i = bw;
      wr_bit_i = !bw;
      bit_pos_i = p;
      wdata_i = d;
      @(negedge clk_sys_i);
      wr_byte_i = 1'b0;
      wr_bit_i = 1'b0;
   endtask
   // Bounded wait for the end pulse; a miss ends the run
   task automatic wait_irq(input int lim, output int cyc);
      cyc = 0;
      do begin
         @(posedge clk_sys_i);
         #1;
         cyc++;
      end while (irq !== 1'b1 && cyc < lim);
      if (irq !== 1'b1) begin
         fails++;
         $display("CHECK FAILED at %0t: conversion end never came", $time);
         stop_test();
      end
   endtask
   task automatic count_irq(input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge clk_sys_i);
         #1;
         if (irq === 1'b1)
            k++;
      end
   endtask
   // Software clears the end flag before any restart
   task automatic clr_flag();
      @(negedge clk_sys_i);
      flag_clr = 1'b1;
      @(negedge clk_sys_i);
      flag_clr = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      check(mode, 8'h01, "mode after reset");
      check({6'h0, flag, busy}, 8'h00, "idle after reset");
      wr(16'hFF81, 1'b1, 3'h0, 8'hFF);
      check(mode, 8'h01, "other address ignored");
      wr(16'hFF80, 1'b1, 3'h0, 8'h3A);
      check(mode, 8'h3A, "byte write");
      check({5'h0, chan}, 8'h05, "channel field");
      wr(16'hFF80, 1'b0, 3'h0, 8'h01);
      wr(16'hFF80, 1'b0, 3'h3, 8'h00);
      check(mode, 8'h33, "bit writes");
      wr(16'hFF80, 1'b1, 3'h0, 8'h01);
   endtask
   // Every channel converted from stop; the bench clears the flag before each restart
   task automatic t_channels();
      int c;
      for (int n = 0; n < 8; n++) begin
         wr(16'hFF80, 1'b1, 3'h0, {4'h8, n[2:0], 1'b1});
         wait_irq(400, c); // No shared port reads while converting
         check(result, levels[n*8 +: 8], "result per channel");
         check({7'h0, flag}, 8'h01, "flag with result");
         wr(16'hFF80, 1'b1, 3'h0, 8'h01);
         clr_flag();
         check({7'h0, flag}, 8'h00, "flag cleared");
      end
   endtask
   // Periods of repeated software conversions; fixed overhead cancels in the differences
   task automatic t_lengths();
      logic [2:0] code [4] = '{3'b001, 3'b011, 3'b100, 3'b101};
      int         shrt [4] = '{80, 40, 50, 100};
      int         p [2];
      int         base;
      int         c;
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 2; m++) begin
            @(negedge clk_sys_i);
            div_sel = (m == 0);
            clr_flag();
            wr(16'hFF80, 1'b1, 3'h0, {2'b10, code[i][2:1], 3'h0, code[i][0]});
            wait_irq(400, c);
            wait_irq(400, p[m]);
            wr(16'hFF80, 1'b1, 3'h0, 8'h01);
         end
         if (i == 0)
            base = p[0];
         check(8'(p[1] - p[0]), 8'(shrt[i]), "long minus short");
         check(8'(p[0] - base), 8'(shrt[i] - 80), "code step");
      end
      @(negedge clk_sys_i);
      div_sel = 1'b1;
   endtask
   task automatic t_stop();
      int k;
      clr_flag();
      wr(16'hFF80, 1'b1, 3'h0, 8'h83);
      repeat (30) @(negedge clk_sys_i);
      wr(16'hFF80, 1'b0, 3'h7, 8'h00);
      repeat (3) @(negedge clk_sys_i);
      check({7'h0, busy}, 8'h00, "stop clears busy");
      count_irq(300, k);
      check(8'(k), 8'h00, "no end after stop");
      check(mode, 8'h03, "run bit cleared");
      check(result, levels[7:0], "aborted run keeps result");
      check({7'h0, flag}, 8'h00, "aborted run sets no flag");
   endtask
   // One pin pulse per edge code: rise, fall, both (second edge held), none
   task automatic t_hw();
      logic [1:0] cfg [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
      int         nexp [4] = '{1, 1, 2, 0};
      int         k;
      clr_flag();
      wr(16'hFF80, 1'b1, 3'h0, 8'hC3);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_sys_i);
         edge_cfg = cfg[i];
         count_irq(40, k);
         check(8'(k) + {7'h0, busy}, 8'h00, "no start without trigger");
         clr_flag();
         trig = 1'b1;
         repeat (3) @(negedge clk_sys_i);
         trig = 1'b0;
         count_irq(400, k);
         check(8'(k), 8'(nexp[i]), "conversions per trigger");
         check({7'h0, flag}, 8'(nexp[i] != 0), "flag after trigger");
      end
      check(result, 8'h7F, "hardware result");
      wr(16'hFF80, 1'b1, 3'h0, 8'h01); // Stop before any standby
   endtask
   task automatic t_pins();
      logic [7:0] cnt [3] = '{8'h00, 8'h03, 8'h08};
      logic [7:0] en [3] = '{8'h00, 8'h07, 8'hFF};
      for (int i = 0; i < 3; i++) begin
         pin_cnt = cnt[i];
         repeat (2) @(negedge clk_sys_i);
         check(pin_en, en[i], "analog pin enables");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      t_regs();
      t_channels();
      t_lengths();
      t_stop();
      t_hw();
      t_pins();
      stop_test();
   end
endmodule
`default_nettype wire
